// ===== hw/osf_iir.sv
`default_nettype none
// ---------------------------------------------------------------------------
// per-bank first-order offset estimators
// ---------------------------------------------------------------------------
module osf_iir
   import osf_pkg::*;
#(
   parameter int unsigned NB   = 4,    // interleaved banks, power of two
   parameter int unsigned DW   = 12,   // sample width
   parameter int unsigned BW   = $clog2(NB)
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   input  wire logic                i_upd,     // update estimate of i_bank
   input  wire logic                i_clr,     // clear every estimate
   input  wire logic [BW-1:0]       i_bank,
   input  wire logic signed [DW:0]  i_x,       // centred sample
   input  wire logic [2:0]          i_shl,     // left shift of the error step
   output logic signed [DW+2:0]     o_est_sel, // estimate of i_bank
   output logic signed [DW+2:0]     o_est_mean // mean over all banks
);
   localparam int unsigned ACC_W = DW + 3 + EST_FRAC;

   logic signed [ACC_W-1:0] acc_r [NB];   // offsets scaled by 2**EST_FRAC
   logic signed [DW+2:0]    err;          // sample minus current estimate
   logic signed [ACC_W-1:0] step;         // error times the coefficient
   logic signed [DW+2+BW:0] sum;          // sum of all estimates

   // -------------------------------------------------------------------------
   // estimate read and step
   // -------------------------------------------------------------------------
   // the step is err * 2**-k scaled by 2**EST_FRAC, so only a left shift is
   // needed; the accumulator keeps the bits that a right shift would lose
   always_comb begin
      o_est_sel = acc_r[i_bank][ACC_W-1:EST_FRAC];
      err       = $signed({{2{i_x[DW]}}, i_x}) - o_est_sel;
      step      = $signed({{EST_FRAC{err[DW+2]}}, err}) <<< i_shl;
      sum       = '0;
      for (int b = 0; b < NB; b++) begin
         sum = sum + $signed({{BW{acc_r[b][ACC_W-1]}}, acc_r[b][ACC_W-1:EST_FRAC]});
      end
      o_est_mean = sum[DW+2+BW:BW];
   end

   // -------------------------------------------------------------------------
   // accumulator update
   // -------------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int b = 0; b < NB; b++) begin
            acc_r[b] <= '0;
         end
      end else if (i_clr) begin
         for (int b = 0; b < NB; b++) begin
            acc_r[b] <= '0;
         end
      end else if (i_upd) begin
         acc_r[i_bank] <= acc_r[i_bank] + step;
      end
   end
endmodule : osf_iir
`default_nettype wire

// ===== hw/osf_pkg.sv
`default_nettype none
// ---------------------------------------------------------------------------
// offset filter control shared constants
// ---------------------------------------------------------------------------
package osf_pkg;
   // bus geometry: each register owns one aligned 32-bit word at index * 4
   localparam int unsigned      WB_ADR_W       = 12;
   localparam int unsigned      WB_DAT_W       = 32;
   localparam int unsigned      REG_IDX_W      = 10;
   // register indices (byte address is four times the index)
   localparam logic [9:0]       IDX_TRIM_B_IN2 = 10'h094;
   localparam logic [9:0]       IDX_FILT_CTL0  = 10'h097;
   localparam logic [9:0]       IDX_FILT_CTL1  = 10'h098;
   localparam logic [9:0]       IDX_CAL_CTL    = 10'h099;
   localparam logic [9:0]       IDX_CAL_STAT   = 10'h09a;
   // trim word layout
   localparam int unsigned      TRIM_LSB       = 0;
   localparam int unsigned      TRIM_W         = 12;
   localparam logic [3:0]       TRIM_RSV_RST   = 4'h0;
   // filter control 0 layout
   localparam int unsigned      KEEP_DC_BIT    = 0;
   localparam logic [7:0]       FILT_CTL0_RST  = 8'h00;
   // filter control 1 layout
   localparam int unsigned      BW_SEL_LSB     = 4;
   localparam int unsigned      SETTLE_SEL_LSB = 0;
   localparam int unsigned      CODE_W         = 4;
   localparam logic [7:0]       FILT_CTL1_RST  = 8'h33;
   // legal coefficient codes: code n gives 2**-(n+9)
   localparam logic [3:0]       BW_CODE_MIN    = 4'h1;
   localparam logic [3:0]       BW_CODE_MAX    = 4'h5;
   // calibration control layout
   localparam int unsigned      FILT_EN_BIT    = 0;
   localparam int unsigned      BG_CAL_BIT     = 1;
   localparam int unsigned      BG_OS_CAL_BIT  = 2;
   localparam int unsigned      OS_CAL_BIT     = 3;
   localparam logic [7:0]       CAL_CTL_RST    = 8'h00;
   // calibration status layout
   localparam int unsigned      FOREGROUND_CAL_COMPLETE_BIT    = 0;
   localparam int unsigned      BG_PAUSED_BIT  = 1;
   localparam int unsigned      FG_BUSY_BIT    = 2;
   localparam int unsigned      SETTLING_BIT   = 3;
   // fractional bits of the offset estimate, equal to the deepest shift
   localparam int unsigned      EST_FRAC       = 14;
   // settle sequencer states, gray along idle -> settle -> release
   typedef enum logic [1:0] {
      OSF_ST_IDLE    = 2'b00,
      OSF_ST_SETTLE  = 2'b01,
      OSF_ST_RELEASE = 2'b11
   } osf_state_type;
endpackage : osf_pkg
`default_nettype wire

// ===== hw/osf_top.sv
// The Wishbone register port was chosen for this implementation.
`default_nettype none
module osf_top
   import osf_pkg::*;
#(
   parameter int unsigned NB             = 4,        // interleaved converter banks
   parameter int unsigned DW             = 12,       // sample width
   parameter logic [1:0]  BANK_B_IDX     = 2'h1,     // index of converter bank b
   parameter logic [11:0] FACTORY_TRIM   = 12'h800,  // factory trim word
   parameter int unsigned SETTLE_UNIT_LOG2 = 9       // settle samples = 2**(unit+code)
) (
   input  wire logic                i_clk,
   input  wire logic                i_rst,
   // classic wishbone slave
   input  wire logic                i_wb_cyc,
   input  wire logic                i_wb_stb,
   input  wire logic                i_wb_we,
   input  wire logic [WB_ADR_W-1:0] i_wb_adr,
   input  wire logic [3:0]          i_wb_sel,
   input  wire logic [WB_DAT_W-1:0] i_wb_dat,
   output logic                     o_wb_ack,
   output logic [WB_DAT_W-1:0]      o_wb_dat,
   // calibration engine status, same clock
   input  wire logic                i_fg_cal_busy,
   input  wire logic                i_foreground_cal_complete,
   input  wire logic                i_background_cal_paused,
   input  wire logic                i_bank_cal_done,      // one-cycle pulse
   input  wire logic [1:0]          i_bank_cal_idx,
   // interleaved sample stream
   input  wire logic                i_smp_valid,
   input  wire logic [1:0]          i_smp_bank,
   input  wire logic                i_smp_second_input,
   input  wire logic [DW-1:0]       i_smp_data,
   output logic                     o_smp_valid,
   output logic [1:0]               o_smp_bank,
   output logic [DW-1:0]            o_smp_data,
   // trim word to converter bank b and calibration controls
   output logic [TRIM_W-1:0]        o_trim_value,
   output logic                     o_trim_apply,
   output logic                     o_offset_filter_enable,
   output logic                     o_background_cal_enable,
   output logic                     o_background_offset_cal_enable,
   output logic                     o_offset_cal_enable,
   output logic [NB-1:0]            o_bank_online
);
   localparam int unsigned BKW = 2;
   localparam logic signed [DW:0] MID  = (DW+1)'(1 << (DW - 1));
   localparam logic signed [DW+2:0] SMAX = (DW+3)'((1 << (DW - 1)) - 1);
   localparam logic signed [DW+2:0] SMIN = -(DW+3)'(1 << (DW - 1));

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   // a bandwidth or settle code is usable only inside 1..5
   function automatic logic code_legal(input logic [3:0] code);
      code_legal = (code >= BW_CODE_MIN) && (code <= BW_CODE_MAX);
   endfunction : code_legal

   // byte-lane merge of one register byte
   function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic       sel);
      lane_merge = sel ? new_v : old_v;
   endfunction : lane_merge

   // -------------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------------
   logic [15:0]              trim_r;         // trim word with reserved top
   logic [7:0]               filt_ctl0_r;    // keep-dc and reserved bits
   logic [7:0]               filt_ctl1_r;    // bandwidth and settle codes
   logic [7:0]               cal_ctl_r;      // calibration enables
   logic                     ack_r;          // bus acknowledge
   logic [WB_DAT_W-1:0]      rdat_r;         // bus read data
   logic                     req;            // new bus request
   logic [REG_IDX_W-1:0]     idx;            // word index of the request
   logic [WB_DAT_W-1:0]      rdat_nxt;       // decoded read data
   logic                     filt_en;        // filter enable bit
   logic                     bg_en;          // background calibration bit
   logic                     keep_dc;        // keep dc content bit
   logic [3:0]               bw_code;        // bandwidth select
   logic [3:0]               settle_code;    // settle time select
   logic                     settle_used;    // settle sequencing active
   osf_state_type            st_r;           // settle sequencer state
   osf_state_type            st_nxt;
   logic [1:0]               settle_bank_r;  // bank that is settling
   logic [SETTLE_UNIT_LOG2+5:0] settle_cnt_r; // remaining settle samples
   logic [NB-1:0]            online_r;       // banks in service
   logic signed [DW:0]       x_ctr;          // centred incoming sample
   logic signed [DW+2:0]     est_sel;        // estimate of incoming bank
   logic signed [DW+2:0]     est_mean;       // mean estimate over banks
   logic signed [DW+2:0]     corr;           // offset removed from sample
   logic signed [DW+2:0]     y_ctr;          // corrected centred sample
   logic signed [DW+2:0]     y_sat;          // saturated corrected sample
   logic                     filt_upd;       // estimator update strobe
   logic                     smp_valid_r;
   logic [1:0]               smp_bank_r;
   logic [DW-1:0]            smp_data_r;
   logic                     trim_apply_r;

   // -------------------------------------------------------------------------
   // register bus
   // -------------------------------------------------------------------------
   assign req = i_wb_cyc && i_wb_stb && !ack_r;
   assign idx = i_wb_adr[WB_ADR_W-1:2];

   // read decode; unmapped words read as zero and are still acknowledged
   always_comb begin
      rdat_nxt = '0;
      case (idx)
         IDX_TRIM_B_IN2: begin
            rdat_nxt[15:0] = trim_r;
         end
         IDX_FILT_CTL0: begin
            rdat_nxt[7:0] = filt_ctl0_r;
         end
         IDX_FILT_CTL1: begin
            rdat_nxt[7:0] = filt_ctl1_r;
         end
         IDX_CAL_CTL: begin
            rdat_nxt[7:0] = cal_ctl_r;
         end
         IDX_CAL_STAT: begin
            // software polls these before trusting a trim read
            rdat_nxt[FOREGROUND_CAL_COMPLETE_BIT]   = i_foreground_cal_complete;
            rdat_nxt[BG_PAUSED_BIT] = i_background_cal_paused;
            rdat_nxt[FG_BUSY_BIT]   = i_fg_cal_busy;
            rdat_nxt[SETTLING_BIT]  = (st_r != OSF_ST_IDLE);
         end
         default: begin
            rdat_nxt = '0;
         end
      endcase
   end

   // one wait state: ack follows the request by one edge and drops after
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ack_r  <= 1'b0;
         rdat_r <= '0;
      end else begin
         ack_r <= req;
         if (req && !i_wb_we) begin
            rdat_r <= rdat_nxt;
         end
      end
   end

   // trim word; writes are trusted to respect the calibration state, since
   // the engine owns the value while it runs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         trim_r <= {TRIM_RSV_RST, FACTORY_TRIM};
      end else if (req && i_wb_we && idx == IDX_TRIM_B_IN2) begin
         trim_r[7:0]  <= lane_merge(trim_r[7:0], i_wb_dat[7:0], i_wb_sel[0]);
         trim_r[15:8] <= lane_merge(trim_r[15:8], i_wb_dat[15:8], i_wb_sel[1]);
      end
   end

   // filter and calibration controls; reserved bits are stored as written
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         filt_ctl0_r <= FILT_CTL0_RST;
         filt_ctl1_r <= FILT_CTL1_RST;
         cal_ctl_r   <= CAL_CTL_RST;
      end else if (req && i_wb_we) begin
         if (idx == IDX_FILT_CTL0) begin
            filt_ctl0_r <= lane_merge(filt_ctl0_r, i_wb_dat[7:0], i_wb_sel[0]);
         end
         if (idx == IDX_FILT_CTL1) begin
            filt_ctl1_r <= lane_merge(filt_ctl1_r, i_wb_dat[7:0], i_wb_sel[0]);
         end
         if (idx == IDX_CAL_CTL) begin
            cal_ctl_r <= lane_merge(cal_ctl_r, i_wb_dat[7:0], i_wb_sel[0]);
         end
      end
   end

   assign filt_en     = cal_ctl_r[FILT_EN_BIT];
   assign bg_en       = cal_ctl_r[BG_CAL_BIT];
   assign keep_dc     = filt_ctl0_r[KEEP_DC_BIT];
   assign bw_code     = filt_ctl1_r[BW_SEL_LSB +: CODE_W];
   assign settle_code = filt_ctl1_r[SETTLE_SEL_LSB +: CODE_W];
   // settle timing only matters when filter and background run together
   assign settle_used = filt_en && bg_en && code_legal(settle_code);

   // -------------------------------------------------------------------------
   // settle sequencer
   // -------------------------------------------------------------------------
   // next state of the settle sequencer
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         OSF_ST_IDLE: begin
            if (i_bank_cal_done && settle_used) begin
               st_nxt = OSF_ST_SETTLE;
            end
         end
         OSF_ST_SETTLE: begin
            // dropping the enables aborts settling and frees the bank
            if (!settle_used || settle_cnt_r == '0) begin
               st_nxt = OSF_ST_RELEASE;
            end
         end
         OSF_ST_RELEASE: begin
            st_nxt = OSF_ST_IDLE;
         end
         default: begin
            st_nxt = OSF_ST_IDLE;
         end
      endcase
   end

   // state, bank and countdown; the count runs in samples of the bank,
   // so its length tracks the filter time constant at any clock rate
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r          <= OSF_ST_IDLE;
         settle_bank_r <= '0;
         settle_cnt_r  <= '0;
      end else begin
         st_r <= st_nxt;
         if (st_r == OSF_ST_IDLE && st_nxt == OSF_ST_SETTLE) begin
            settle_bank_r <= i_bank_cal_idx;
            settle_cnt_r  <= (SETTLE_UNIT_LOG2+6)'(1) << (SETTLE_UNIT_LOG2 +
                             32'(settle_code));
         end else if (st_r == OSF_ST_SETTLE && settle_cnt_r != '0 && i_smp_valid
                      && i_smp_bank == settle_bank_r) begin
            settle_cnt_r <= settle_cnt_r - 1'b1;
         end
      end
   end

   // bank service flags: a calibrated bank waits out its settle time
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         online_r <= '1;
      end else begin
         if (st_r == OSF_ST_IDLE && st_nxt == OSF_ST_SETTLE) begin
            online_r[i_bank_cal_idx] <= 1'b0;
         end else if (st_r == OSF_ST_RELEASE) begin
            online_r[settle_bank_r] <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------------
   // offset filter
   // -------------------------------------------------------------------------
   assign x_ctr = $signed({1'b0, i_smp_data}) - MID;
   // reserved codes freeze the estimates rather than guess a coefficient
   assign filt_upd = i_smp_valid && filt_en && code_legal(bw_code);

   osf_iir #(
      .NB (NB),
      .DW (DW),
      .BW (BKW)
   ) u_iir (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_upd      (filt_upd),
      .i_clr      (!filt_en),
      .i_bank     (i_smp_bank),
      .i_x        (x_ctr),
      // coefficient 2**-(9+code): the shift sets bandwidth relative to the
      // sample clock, so it scales with clock and halves per code
      .i_shl      (3'(BW_CODE_MAX - bw_code)),
      .o_est_sel  (est_sel),
      .o_est_mean (est_mean)
   );

   // correction choice and saturation back to the sample range
   always_comb begin
      if (!filt_en) begin
         corr = '0;
      end else if (keep_dc) begin
         corr = est_sel - est_mean;
      end else begin
         corr = est_sel;
      end
      y_ctr = $signed({{2{x_ctr[DW]}}, x_ctr}) - corr;
      if (y_ctr > SMAX) begin
         y_sat = SMAX;
      end else if (y_ctr < SMIN) begin
         y_sat = SMIN;
      end else begin
         y_sat = y_ctr;
      end
   end

   // registered output stream, one cycle behind the input
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         smp_valid_r  <= 1'b0;
         smp_bank_r   <= '0;
         smp_data_r   <= '0;
         trim_apply_r <= 1'b0;
      end else begin
         smp_valid_r  <= i_smp_valid;
         smp_bank_r   <= i_smp_bank;
         smp_data_r   <= DW'(y_sat + (DW+3)'(MID));
         trim_apply_r <= i_smp_valid && i_smp_second_input
                         && i_smp_bank == BANK_B_IDX;
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   assign o_wb_ack                       = ack_r;
   assign o_wb_dat                       = rdat_r;
   assign o_smp_valid                    = smp_valid_r;
   assign o_smp_bank                     = smp_bank_r;
   assign o_smp_data                     = smp_data_r;
   assign o_trim_value                   = trim_r[TRIM_LSB +: TRIM_W];
   assign o_trim_apply                   = trim_apply_r;
   assign o_offset_filter_enable         = cal_ctl_r[FILT_EN_BIT];
   assign o_background_cal_enable        = cal_ctl_r[BG_CAL_BIT];
   assign o_background_offset_cal_enable = cal_ctl_r[BG_OS_CAL_BIT];
   assign o_offset_cal_enable            = cal_ctl_r[OS_CAL_BIT];
   assign o_bank_online                  = online_r;
endmodule : osf_top
`default_nettype wire

// ===== sim/osf_top_checker.sv
`default_nettype none
// ---------------------------------------------------------------------------
// port checker
// ---------------------------------------------------------------------------
module osf_top_checker
   import osf_pkg::*;
#(
   parameter int unsigned NB = 4  // banks
) (
   input wire logic          i_clk,
   input wire logic          i_rst,
   input wire logic          i_wb_cyc,
   input wire logic          i_wb_stb,
   input wire logic          o_wb_ack,
   input wire logic          i_smp_valid,
   input wire logic [1:0]    i_smp_bank,
   input wire logic          i_smp_second_input,
   input wire logic [11:0]   i_smp_data,
   input wire logic          o_smp_valid,
   input wire logic [1:0]    o_smp_bank,
   input wire logic [11:0]   o_smp_data,
   input wire logic          o_trim_apply,
   input wire logic          i_bank_cal_done,
   input wire logic          o_offset_filter_enable,
   input wire logic          o_background_cal_enable,
   input wire logic [NB-1:0] o_bank_online
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // a taken request is answered exactly one cycle later, for one cycle
   chk_ack_after_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack missing after request");
   chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   chk_ack_no_request: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
      else $error("ack without request");
   chk_smp_valid_lat: assert property (##1 o_smp_valid == $past(i_smp_valid))
      else $error("sample valid latency wrong");
   chk_smp_bank_kept: assert property (i_smp_valid |=> o_smp_bank == $past(i_smp_bank))
      else $error("sample bank changed");
   chk_trim_apply_b: assert property (
      ##1 o_trim_apply == $past(i_smp_valid && i_smp_bank == 2'h1 && i_smp_second_input))
      else $error("trim apply wrong");
   chk_filter_off_pass: assert property (
      i_smp_valid && !o_offset_filter_enable |=> o_smp_data == $past(i_smp_data))
      else $error("data altered with filter off");
   // a bank leaves service only after a done pulse with both enables on
   chk_settle_start: assert property (
      ($past(o_bank_online) & ~o_bank_online) != '0
      |-> $past(i_bank_cal_done && o_offset_filter_enable && o_background_cal_enable))
      else $error("bank taken offline without cause");
   cov_ack: cover property (o_wb_ack);
   cov_apply: cover property (o_trim_apply);
   cov_offline: cover property (o_bank_online != '1);
endmodule : osf_top_checker
bind osf_top osf_top_checker #(.NB(NB)) chk_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
   .i_smp_valid(i_smp_valid), .i_smp_bank(i_smp_bank),
   .i_smp_second_input(i_smp_second_input), .i_smp_data(i_smp_data),
   .o_smp_valid(o_smp_valid), .o_smp_bank(o_smp_bank), .o_smp_data(o_smp_data),
   .o_trim_apply(o_trim_apply), .i_bank_cal_done(i_bank_cal_done),
   .o_offset_filter_enable(o_offset_filter_enable),
   .o_background_cal_enable(o_background_cal_enable), .o_bank_online(o_bank_online));
`default_nettype wire

// ===== sim/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_rst = 1, i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0, o_wb_ack;
   logic [11:0] i_wb_adr = '0, i_smp_data = '0, o_smp_data, o_trim_value;
   logic [3:0]  i_wb_sel = '0, o_bank_online;
   logic [31:0] i_wb_dat = '0, o_wb_dat, rnd = 32'hc4fa, rd;
   logic [1:0]  i_bank_cal_idx = '0, i_smp_bank = '0, o_smp_bank;
   logic i_fg_cal_busy = 0, i_foreground_cal_complete = 0, i_background_cal_paused = 0;
   logic i_bank_cal_done = 0, i_smp_valid = 0, i_smp_second_input = 0, o_smp_valid;
   logic o_trim_apply, o_offset_filter_enable, o_background_cal_enable;
   logic o_background_offset_cal_enable, o_offset_cal_enable;
   int n_errors = 0, checks_done = 0;
   osf_top #(.SETTLE_UNIT_LOG2(1)) osf_top_inst (.i_clk, .i_rst, .i_wb_cyc, .i_wb_stb,
      .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat, .i_fg_cal_busy,
      .i_foreground_cal_complete, .i_background_cal_paused, .i_bank_cal_done,
      .i_bank_cal_idx, .i_smp_valid, .i_smp_bank, .i_smp_second_input, .i_smp_data,
      .o_smp_valid, .o_smp_bank, .o_smp_data, .o_trim_value, .o_trim_apply,
      .o_offset_filter_enable, .o_background_cal_enable, .o_background_offset_cal_enable,
      .o_offset_cal_enable, .o_bank_online);
   always #20 i_clk = ~i_clk;  // 25 MHz
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // trim is applied only to bank b on the second input
   function automatic logic exp_apply(input logic [1:0] b, input logic s);
      return (b == 2'h1) && s;
   endfunction : exp_apply
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : check
   // classic cycle: hold until ack is sampled, then release
   task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat, i_wb_sel} <= {2'b11, we, a, d, 4'hf};
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'b00;
   endtask : wb
   task automatic smp(input logic [1:0] b, input logic s, input logic [11:0] d);
      @(posedge i_clk);
      {i_smp_valid, i_smp_bank, i_smp_second_input, i_smp_data} <= {1'b1, b, s, d};
      @(posedge i_clk);
      i_smp_valid <= 1'b0;
   endtask : smp
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      // reset values and an unmapped place
      wb(0, 12'h250, 0); check(rd, 32'h0800, "trim reset");
      wb(0, 12'h25c, 0); check(rd, 32'h00, "ctl0 reset");
      wb(0, 12'h260, 0); check(rd, 32'h33, "ctl1 reset");
      wb(1, 12'h300, 32'hff); wb(0, 12'h300, 0); check(rd, 0, "unmapped");
      $display("test reset done");
      // random register traffic, read back
      for (int i = 0; i < 6; i++) begin
         logic [3:0] c;
         rnd = lfsr(rnd);
         // legal codes only, settle code equal to bandwidth code
         c = 4'(rnd[18:16] % 3'd5) + 4'h1;
         wb(1, 12'h250, {20'h0, rnd[11:0]});
         wb(0, 12'h250, 0);
         check(rd, {20'h0, rnd[11:0]}, "trim rw");
         check(o_trim_value, rnd[11:0], "trim out");
         wb(1, 12'h260, {24'h0, c, c});
         wb(0, 12'h260, 0);
         check(rd, {24'h0, c, c}, "ctl1 rw");
      end
      $display("test registers done");
      // filter off: samples pass unchanged, apply only for bank b input two
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         smp(rnd[1:0], rnd[2], rnd[15:4]);
         @(posedge i_clk);
         check(o_smp_data, rnd[15:4], "bypass");
         check(o_smp_valid, 1'b1, "valid");
         check(o_smp_bank, rnd[1:0], "bank");
         check(o_trim_apply, exp_apply(rnd[1:0], rnd[2]), "apply rnd");
      end
      smp(2'h1, 1'b1, 12'h123);
      @(posedge i_clk);
      check(o_trim_apply, exp_apply(2'h1, 1'b1), "apply");
      $display("test stream done");
      // settle: code 3 with unit 1 needs 16 samples of the bank
      wb(1, 12'h260, 32'h33);
      wb(1, 12'h264, 32'h0f);
      check(o_background_cal_enable, 1'b1, "bg copy");
      check(o_offset_filter_enable, 1'b1, "filt copy");
      check({o_offset_cal_enable, o_background_offset_cal_enable}, 2'h3, "os copy");
      @(posedge i_clk); {i_bank_cal_done, i_bank_cal_idx} <= 3'b110;
      @(posedge i_clk); i_bank_cal_done <= 1'b0;
      {i_foreground_cal_complete, i_background_cal_paused} <= 2'b11;
      @(posedge i_clk); check(o_bank_online, 4'hb, "offline");
      wb(0, 12'h268, 0);
      check(rd, 32'hb, "status");
      for (int i = 0; i < 15; i++) smp(2'h2, 1'b0, 12'h800);
      repeat (4) @(posedge i_clk);
      check(o_bank_online, 4'hb, "early");
      smp(2'h2, 1'b0, 12'h800);
      repeat (4) @(posedge i_clk);
      check(o_bank_online, 4'hf, "online");
      $display("test settle done");
      // equal offsets on all banks: keep-dc removes nothing, else dc goes
      wb(1, 12'h25c, 32'h01);
      for (int i = 0; i < 32; i++) begin
         if (i == 16) wb(1, 12'h25c, 32'h00);
         smp(2'(i), 1'b0, 12'hfff);
         @(posedge i_clk);
         if (i < 16) check(o_smp_data, 12'hfff, "keep dc");
      end
      check(o_smp_data < 12'hfff, 1'b1, "dc removed");
      $display("test filter done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
